// [design/pss_hold.sv]
`timescale 1ns/1ps
// ============================================================
// holdover duration in whole seconds
module pss_hold import pss_pkg::*; (
  input wire logic mclk, // clock
  input wire logic rst, // async reset
  input wire logic inHold, // currently in holdover
  input wire logic tick, // one second elapsed
  output logic [31:0] holdSecs, // current or previous duration
  output logic holdState // 1 in holdover
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      holdSecs <= 32'h0;
      holdState <= 1'b0;
    end else begin
      holdState <= inHold; // see R12
      // count restarts on entry, is frozen after exit
      if (inHold && !holdState) holdSecs <= 32'h0;
      else if (inHold && tick && holdSecs != 32'hffffffff) holdSecs <= holdSecs + 32'h1; // see R12
    end
  end
endmodule

// [design/pss_sync_status.sv]
`timescale 1ns/1ps
// Overview of operation
// R1 - keyed field: 0 unkeyed, 1 keyed
// R2 - verification: 0 ok, 3, 5, 7 codes
// R3 - expiration field: 1 when expiry imminent
// R4 - processor health: 0 alive, 1 dead
// R5 - spoof protection: 0 ok, 1 error
// R6 - status sentence every N seconds, N 0..255
// R7 - rate command ignored during two-minute warm-up
// R8 - sentence carries previous-second time, fields, checksum
// R9 - zeroize needs start parameter, reports result
// R10 - time forwarding sends date, time each second
// R11 - stored leap offset until almanac, then receiver's
// R12 - holdover seconds count plus holdover state flag
// R13 - forced holdover stops locking, keeps measuring
// R14 - forced holdover exit resumes normal locking
// R15 - select satellite or external; auto uses holdover
// R16 - measure output-to-satellite pulse offset, 0.1 ns
// R17 - instant align only when not in holdover
// R18 - frequency error from offset over 1000 s
// R19 - lock state: 0 unlocked, 1 locked
// R20 - pulse before lock, then ten equal steps; here the last step takes the division remainder
// R21 - default off: pulse suppressed until lock
// R22 - 24-hour utc time and calendar date
// R23 - zeroize result 0 ok, 1 failed, 2 none
// R24 - key fill valid shown at least one second
// R25 - auto mode returns to satellite after holdover
module pss_sync_status import pss_pkg::*; #(
  parameter int CYCLES_PER_SEC = SEC_CYCLES // shorten in simulation
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic rst, // async reset
  input wire logic cvKeyed, // receiver keyed
  input wire logic noCvs, // no variables present
  input wire logic notCurrent, // variables not current
  input wire logic navPending, // navigation pending
  input wire logic cvExpiring, // expiration imminent
  input wire logic kdpDead, // key processor dead
  input wire logic spoofError, // anti-spoof error
  input wire logic fillValid, // key fill valid
  input wire logic [3:0] ytrack, // y-code sats tracked
  input wire logic [1:0] xferState, // pass-through transfer
  input wire logic [1:0] pvtState, // pass-through state
  input wire logic pvtMode, // pass-through mode
  input wire logic rateWr, // status rate command
  input wire logic [7:0] rateVal, // rate in seconds
  input wire logic zeroizeCmd, // zeroize command
  input wire logic zeroizeStart, // start parameter present
  input wire logic zeroizeDone, // receiver finished
  input wire logic zeroizeOk, // result verified
  input wire logic timeFwdEn, // time forwarding on
  input wire logic loadTime, // set time
  input wire logic loadDate, // set date
  input wire logic [4:0] setHour, // value
  input wire logic [5:0] setMin, // value
  input wire logic [5:0] setSec, // value
  input wire logic [11:0] setYear, // value
  input wire logic [3:0] setMonth, // value
  input wire logic [4:0] setDay, // value
  input wire logic almanacValid, // almanac received
  input wire logic [7:0] leapNv, // stored leap offset
  input wire logic [7:0] leapGps, // receiver leap offset
  input wire logic gpsPps, // satellite pulse
  input wire logic extPps, // external pulse
  input wire logic gpsLocked, // receiver locked
  input wire logic gpsHoldover, // receiver in holdover
  input wire logic forcedHoldCmd, // forced holdover entry
  input wire logic forcedHoldExit, // forced holdover exit
  input wire logic [1:0] srcMode, // pss_src_e
  input wire logic instAlign, // instant align command
  input wire logic ppsBeforeLockEn, // pulse before lock
  output logic ppsOut, // output pulse
  output logic refSelExt, // external reference selected
  output logic keyedField, // keyed status
  output logic [2:0] verifField, // verification status
  output logic expField, // expiration warning
  output logic kdpField, // processor health
  output logic spoofField, // spoof protection
  output logic keyFillField, // key fill status
  output logic [1:0] zeroField, // zeroize result
  output logic zeroizeReq, // start zeroize
  output logic zeroizeRefused, // command rejected
  output logic rateRefused, // rate write ignored
  output logic sentenceFire, // emit status sentence
  output logic [4:0] stHour, // previous-second time
  output logic [5:0] stMin, // previous-second time
  output logic [5:0] stSec, // previous-second time
  output logic [7:0] stChecksum, // sentence checksum
  output logic fwdDate, // send date init
  output logic fwdTime, // send time init
  output logic [4:0] hour, // time of day
  output logic [5:0] minute, // time of day
  output logic [5:0] second, // time of day
  output logic [11:0] year, // date
  output logic [3:0] month, // date
  output logic [4:0] day, // date
  output logic [7:0] leapOut, // applied leap offset
  output logic [31:0] holdSecs, // holdover duration
  output logic holdState, // holdover flag
  output logic [TINT_W-1:0] tint, // offset in 0.1 ns
  output logic signed [TINT_W-1:0] frequency_error_estimate, // offset change per interval
  output logic lockState // loop locked
);
  // ============================================================
  // second timing and reference selection
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(CYCLES_PER_SEC - 1);
  logic [PH_W-1:0] ph;
  logic [PH_W-1:0] stepAmt;
  logic [PH_W-1:0] measCnt;
  logic [PH_W-1:0] lastOffset;
  logic [3:0] stepsLeft;
  logic wrap, refPulse, inHold, forcedHold, alignPending, everLocked, measuring;
  logic lockPrev, warm;
  logic [7:0] warmSecs, rate, rateCnt;
  logic [9:0] feeSecs;
  logic [TINT_W-1:0] feeStart;
  logic [PH_W-1:0] fillCnt;
  pss_zero_e zState;

  assign wrap = ph == PH_LAST;
  assign inHold = forcedHold || gpsHoldover;
  assign refPulse = refSelExt ? extPps : gpsPps;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) refSelExt <= 1'b0;
    else refSelExt <= srcMode == SRC_EXT || (srcMode == SRC_AUTO && gpsHoldover); // see R15 see R25
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) forcedHold <= 1'b0;
    else if (forcedHoldCmd) forcedHold <= 1'b1; // see R13
    else if (forcedHoldExit) forcedHold <= 1'b0; // see R14
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lockState <= 1'b0;
      lockPrev <= 1'b0;
      everLocked <= 1'b0;
    end else begin
      lockState <= gpsLocked && !forcedHold; // see R19 see R13
      lockPrev <= lockState;
      if (lockState) everLocked <= 1'b1;
    end
  end

  // a jump request waits for the next reference edge; the set wins over the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) alignPending <= 1'b0;
    else begin
      if (refPulse) alignPending <= 1'b0;
      if (instAlign && !inHold) alignPending <= 1'b1; // see R17
      if (lockState && !lockPrev && !ppsBeforeLockEn) alignPending <= 1'b1; // see R21
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ph <= PH_ZERO;
    else if (alignPending && refPulse && !inHold) ph <= PH_ZERO; // see R17
    else if (wrap) ph <= (stepsLeft != 4'h0) ? stepAmt : PH_ZERO; // see R20
    else ph <= ph + PH_W'(1);
  end

  // stepping advances the next pulse; the last step takes the division remainder
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stepsLeft <= 4'h0;
      stepAmt <= PH_ZERO;
    end else if (lockState && !lockPrev && ppsBeforeLockEn) begin
      stepsLeft <= ALIGN_STEPS; // see R20
      stepAmt <= lastOffset / PH_W'(ALIGN_STEPS);
    end else if (wrap && stepsLeft != 4'h0) begin
      stepsLeft <= stepsLeft - 4'h1;
      if (stepsLeft == 4'h2) stepAmt <= lastOffset - stepAmt * PH_W'(ALIGN_STEPS - 4'h1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ppsOut <= 1'b0;
    else ppsOut <= wrap && (ppsBeforeLockEn || everLocked); // see R21 see R20
  end

  // ============================================================
  // offset measurement, runs in forced holdover too
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      measuring <= 1'b0;
      measCnt <= PH_ZERO;
      lastOffset <= PH_ZERO;
      tint <= '0;
    end else if (gpsPps) begin
      // a satellite pulse on our own wrap edge is a zero offset, not a fresh full second
      measuring <= !wrap; // see R13
      measCnt <= PH_W'(1);
      if (wrap) lastOffset <= PH_ZERO;
      if (wrap) tint <= '0; // see R16
    end else if (measuring && wrap) begin
      measuring <= 1'b0;
      lastOffset <= measCnt;
      tint <= TINT_W'(measCnt) * TENTHS_PER_CYC; // see R16
    end else if (measuring) begin
      measCnt <= (measCnt == PH_LAST) ? measCnt : measCnt + PH_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      feeSecs <= 10'h0;
      feeStart <= '0;
      frequency_error_estimate <= '0;
    end else if (wrap) begin
      if (feeSecs == FEE_INTERVAL_S - 10'h1) begin
        feeSecs <= 10'h0;
        feeStart <= tint;
        frequency_error_estimate <= $signed(tint - feeStart); // see R18
      end else begin
        feeSecs <= feeSecs + 10'h1;
      end
    end
  end

  // ============================================================
  // time, calendar, holdover and leap second
  pss_tod u_tod (
    .mclk(mclk), .rst(rst), .tick(wrap), .loadTime(loadTime), .loadDate(loadDate),
    .setHour(setHour), .setMin(setMin), .setSec(setSec), .setYear(setYear),
    .setMonth(setMonth), .setDay(setDay), .hour(hour), .minute(minute), .second(second),
    .year(year), .month(month), .day(day)
  );

  pss_hold u_hold (
    .mclk(mclk), .rst(rst), .inHold(inHold), .tick(wrap), .holdSecs(holdSecs), .holdState(holdState)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) leapOut <= 8'h0;
    else leapOut <= almanacValid ? leapGps : leapNv; // see R11
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fwdDate <= 1'b0;
      fwdTime <= 1'b0;
    end else begin
      fwdDate <= wrap && timeFwdEn; // see R10
      fwdTime <= fwdDate;
    end
  end

  // ============================================================
  // security status fields
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keyedField <= KEYED_NO;
      verifField <= VERIF_NO_CV;
      expField <= 1'b0;
      kdpField <= 1'b0;
      spoofField <= 1'b0;
    end else begin
      keyedField <= cvKeyed ? KEYED_YES : KEYED_NO; // see R1
      verifField <= verif_code(noCvs, notCurrent, navPending); // see R2
      expField <= cvExpiring; // see R3
      kdpField <= kdpDead; // see R4
      spoofField <= spoofError; // see R5
    end
  end

  // a short valid pulse is stretched to a full second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fillCnt <= PH_ZERO;
      keyFillField <= 1'b0;
    end else begin
      if (fillValid) fillCnt <= PH_LAST;
      else if (fillCnt != PH_ZERO) fillCnt <= fillCnt - PH_W'(1);
      keyFillField <= fillValid || fillCnt != PH_ZERO; // see R24
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zState <= Z_IDLE;
      zeroField <= ZERO_NONE;
      zeroizeReq <= 1'b0;
      zeroizeRefused <= 1'b0;
    end else begin
      zeroizeReq <= 1'b0;
      zeroizeRefused <= zeroizeCmd && !zeroizeStart; // see R9
      case (zState)
        Z_IDLE: begin
          if (zeroizeCmd && zeroizeStart) begin
            zeroizeReq <= 1'b1; // see R9
            zState <= Z_BUSY;
          end
        end
        Z_BUSY: begin
          if (zeroizeDone) begin
            zeroField <= zeroizeOk ? ZERO_OK : ZERO_FAIL; // see R23
            zState <= Z_IDLE;
          end
        end
        default: zState <= Z_IDLE;
      endcase
    end
  end

  // ============================================================
  // warm-up gate and periodic status sentence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      warmSecs <= 8'h0;
      warm <= 1'b0;
    end else if (wrap && !warm) begin
      warmSecs <= warmSecs + 8'h1;
      warm <= warmSecs == WARMUP_S - 8'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rate <= 8'h0;
      rateRefused <= 1'b0;
    end else begin
      rateRefused <= rateWr && !warm; // see R7
      if (rateWr && warm) rate <= rateVal; // see R6
    end
  end

  // previous-second time is latched as the second rolls
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rateCnt <= 8'h0;
      sentenceFire <= 1'b0;
      stHour <= 5'h0;
      stMin <= 6'h0;
      stSec <= 6'h0;
      stChecksum <= 8'h0;
    end else begin
      sentenceFire <= 1'b0;
      if (wrap) begin
        stHour <= hour; // see R8
        stMin <= minute;
        stSec <= second;
        if (rate == 8'h0) rateCnt <= 8'h0;
        else if (rateCnt + 8'h1 >= rate) begin
          rateCnt <= 8'h0;
          sentenceFire <= 1'b1; // see R6
          stChecksum <= {3'h0, hour} ^ {2'h0, minute} ^ {2'h0, second} ^ {4'h0, ytrack} ^
                        {zeroField, keyedField, keyFillField, verifField, expField} ^
                        {kdpField, spoofField, xferState, pvtState, pvtMode, 1'b0}; // see R8
        end else rateCnt <= rateCnt + 8'h1;
      end
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_keyed; cvKeyed |=> keyedField == KEYED_YES; endproperty
  a_keyed: assert property (p_keyed) else $error("keyed field wrong"); // see R1
  property p_verif; noCvs |=> verifField == VERIF_NO_CV; endproperty
  a_verif: assert property (p_verif) else $error("verification code wrong"); // see R2
  property p_rate_warm; rateWr && !warm |=> rateRefused && rate == $past(rate); endproperty
  a_rate_warm: assert property (p_rate_warm) else $error("rate taken in warm-up"); // see R7
  property p_zero_rej; zeroizeCmd && !zeroizeStart |=> zeroizeRefused && !zeroizeReq; endproperty
  a_zero_rej: assert property (p_zero_rej) else $error("zeroize without start"); // see R9
  property p_zero_fail; zState == Z_BUSY && zeroizeDone && !zeroizeOk |=> zeroField == ZERO_FAIL; endproperty
  a_zero_fail: assert property (p_zero_fail) else $error("zeroize fail not shown"); // see R23
  property p_hold; inHold |-> ##1 holdState; endproperty
  a_hold: assert property (p_hold) else $error("holdover flag missing"); // see R12
  property p_forced; forcedHold |=> !lockState; endproperty
  a_forced: assert property (p_forced) else $error("locked in forced holdover"); // see R13
  property p_gate; !ppsBeforeLockEn && !everLocked |=> !ppsOut; endproperty
  a_gate: assert property (p_gate) else $error("pulse before lock"); // see R21
  property p_auto; srcMode == SRC_AUTO && gpsHoldover |=> refSelExt; endproperty
  a_auto: assert property (p_auto) else $error("auto did not switch"); // see R15
  property p_leap; !almanacValid |=> leapOut == $past(leapNv); endproperty
  a_leap: assert property (p_leap) else $error("wrong leap source"); // see R11
  property p_fill; $rose(keyFillField) |=> keyFillField [*8]; endproperty
  a_fill: assert property (p_fill) else $error("fill valid too short"); // see R24
  property p_fwd; fwdDate |=> fwdTime ##1 !fwdTime; endproperty
  a_fwd: assert property (p_fwd) else $error("time init not after date"); // see R10

  property p_cov_sent; sentenceFire; endproperty
  c_sent: cover property (p_cov_sent);
  property p_cov_zero; zState == Z_BUSY ##[1:50] zeroField == ZERO_OK; endproperty
  c_zero: cover property (p_cov_zero);
  property p_cov_step; stepsLeft == ALIGN_STEPS; endproperty
  c_step: cover property (p_cov_step);
endmodule

// [design/pss_tod.sv]
`timescale 1ns/1ps
// ============================================================
// utc time of day and calendar, stepped by the second tick
module pss_tod import pss_pkg::*; (
  input wire logic mclk, // clock
  input wire logic rst, // async reset
  input wire logic tick, // one second elapsed
  input wire logic loadTime, // load hours/min/sec
  input wire logic loadDate, // load year/month/day
  input wire logic [4:0] setHour, // load value
  input wire logic [5:0] setMin, // load value
  input wire logic [5:0] setSec, // load value
  input wire logic [11:0] setYear, // load value
  input wire logic [3:0] setMonth, // load value
  input wire logic [4:0] setDay, // load value
  output logic [4:0] hour, // 0..23
  output logic [5:0] minute, // 0..59
  output logic [5:0] second, // 0..59
  output logic [11:0] year, // year
  output logic [3:0] month, // 1..12
  output logic [4:0] day // 1..31
);
  logic dayWrap;
  assign dayWrap = tick && second == SEC_PER_MIN - 6'h1 && minute == MIN_PER_HOUR - 6'h1 &&
                   hour == HOURS_PER_DAY - 5'h1;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hour <= 5'h0;
      minute <= 6'h0;
      second <= 6'h0;
    end else if (loadTime) begin
      hour <= setHour;
      minute <= setMin;
      second <= setSec;
    end else if (tick) begin
      second <= (second == SEC_PER_MIN - 6'h1) ? 6'h0 : second + 6'h1;
      if (second == SEC_PER_MIN - 6'h1) begin
        minute <= (minute == MIN_PER_HOUR - 6'h1) ? 6'h0 : minute + 6'h1;
        if (minute == MIN_PER_HOUR - 6'h1) hour <= (hour == HOURS_PER_DAY - 5'h1) ? 5'h0 : hour + 5'h1; // see R22
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      year <= YEAR_RST;
      month <= MONTH_RST;
      day <= DAY_RST;
    end else if (loadDate) begin
      year <= setYear;
      month <= setMonth;
      day <= setDay;
    end else if (dayWrap) begin
      if (day == days_in_month(month, year)) begin
        day <= DAY_RST;
        month <= (month == MONTHS) ? MONTH_RST : month + 4'h1;
        if (month == MONTHS) year <= year + 12'h1;
      end else begin
        day <= day + 5'h1;
      end
    end
  end
endmodule

// [include/pss_pkg.sv]
// ============================================================
// shared constants for the pulse sync and status block
package pss_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam longint SEC_NS = 64'd1000000000;
  localparam int SEC_CYCLES = int'(SEC_NS / CLK_PERIOD_NS);
  localparam int PH_W = 25;
  localparam int TINT_W = 34;
  // measured offset is reported in tenths of a nanosecond
  localparam logic [TINT_W-1:0] TENTHS_PER_CYC = TINT_W'(CLK_PERIOD_NS * 10);
  localparam int WARMUP_MIN = 2;
  localparam logic [7:0] WARMUP_S = 8'(WARMUP_MIN * 60);
  localparam logic [9:0] FEE_INTERVAL_S = 10'd1000;
  localparam logic [3:0] ALIGN_STEPS = 4'ha;
  localparam logic [PH_W-1:0] PH_ZERO = 25'h0;
  // status field encodings
  localparam logic KEYED_NO = 1'b0;
  localparam logic KEYED_YES = 1'b1;
  localparam logic [2:0] VERIF_OK = 3'h0;
  localparam logic [2:0] VERIF_NAV_PEND = 3'h3;
  localparam logic [2:0] VERIF_NOT_CUR = 3'h5;
  localparam logic [2:0] VERIF_NO_CV = 3'h7;
  localparam logic [1:0] ZERO_OK = 2'h0;
  localparam logic [1:0] ZERO_FAIL = 2'h1;
  localparam logic [1:0] ZERO_NONE = 2'h2;
  // calendar reset value
  localparam logic [11:0] YEAR_RST = 12'h7d0;
  localparam logic [3:0] MONTH_RST = 4'h1;
  localparam logic [4:0] DAY_RST = 5'h01;
  localparam logic [4:0] HOURS_PER_DAY = 5'h18;
  localparam logic [5:0] MIN_PER_HOUR = 6'h3c;
  localparam logic [5:0] SEC_PER_MIN = 6'h3c;
  localparam logic [3:0] MONTHS = 4'hc;

  typedef enum logic [1:0] {SRC_GPS, SRC_EXT, SRC_AUTO} pss_src_e;
  typedef enum logic {Z_IDLE, Z_BUSY} pss_zero_e;

  function automatic logic [4:0] days_in_month(input logic [3:0] mo, input logic [11:0] yr);
    case (mo)
      4'h2: days_in_month = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: days_in_month = 5'h1e;
      default: days_in_month = 5'h1f;
    endcase
  endfunction

  // worst condition wins
  function automatic logic [2:0] verif_code(input logic noCv, input logic notCur, input logic navPend);
    if (noCv) verif_code = VERIF_NO_CV;
    else if (notCur) verif_code = VERIF_NOT_CUR;
    else if (navPend) verif_code = VERIF_NAV_PEND;
    else verif_code = VERIF_OK;
  endfunction
endpackage

// [verif/pss_ref_pulse.sv]
`timescale 1ns/1ps
// ============================================================
// satellite and external reference pulses at fixed places in the second
module pss_ref_pulse #(
  parameter int PERIOD = 100, // cycles per second
  parameter int OFFSET = 7 // satellite pulse position
) (
  input wire logic mclk, // clock
  input wire logic rst, // async reset
  output logic gpsPps, // satellite pulse
  output logic extPps // external pulse
);
  int cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      gpsPps <= 1'b0;
      extPps <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      gpsPps <= (cnt == OFFSET);
      extPps <= (cnt == OFFSET + 20);
    end
  end
endmodule

// [verif/test_pss_sync_status.sv]
`timescale 1ns/1ps
// ============================================================
// bench: short second so warm-up fits the run
module test_pss_sync_status;
  import pss_pkg::*;
  localparam int P = 100;
  logic mclk = 1'b0, rst = 1'b1, gpsPps, extPps, pvtMode, instAlign;
  logic cvKeyed, noCvs, notCurrent, navPending, cvExpiring, kdpDead, spoofError, fillValid, rateWr, zeroizeCmd;
  logic zeroizeStart, zeroizeDone, zeroizeOk, timeFwdEn, loadTime, loadDate, almanacValid, gpsLocked, gpsHoldover;
  logic forcedHoldCmd, forcedHoldExit, ppsBeforeLockEn, ppsOut, refSelExt, keyedField, expField, kdpField;
  logic spoofField, keyFillField, zeroizeReq, zeroizeRefused, rateRefused, sentenceFire, fwdDate, fwdTime;
  logic holdState, lockState;
  logic [1:0] xferState, pvtState, srcMode, zeroField;
  logic [2:0] verifField;
  logic [3:0] ytrack, setMonth, month;
  logic [4:0] setHour, setDay, stHour, hour, day;
  logic [5:0] setMin, setSec, stMin, stSec, minute, second;
  logic [7:0] rateVal, leapNv, leapGps, stChecksum, leapOut;
  logic [11:0] setYear, year;
  logic [31:0] holdSecs;
  logic [TINT_W-1:0] tint;
  logic signed [TINT_W-1:0] frequency_error_estimate;
  int miscompares = 0, comparisons = 0, nReq = 0, nRef = 0, nRate = 0, nFire = 0, nFwd = 0, nPps = 0, f0, w0;
  logic [2:0] vIn [4] = '{3'h7, 3'h2, 3'h1, 3'h0};
  logic [2:0] vExp [4] = '{VERIF_NO_CV, VERIF_NOT_CUR, VERIF_NAV_PEND, VERIF_OK};

  pss_sync_status #(.CYCLES_PER_SEC(P)) uut (.*);
  pss_ref_pulse #(.PERIOD(P), .OFFSET(7)) model (.mclk(mclk), .rst(rst), .gpsPps(gpsPps), .extPps(extPps));

  always #20 mclk = ~mclk;
  // pulses are counted rather than caught, so answer latency does not matter
  always @(posedge mclk) begin
    nReq <= nReq + (zeroizeReq === 1'b1);
    nRef <= nRef + (zeroizeRefused === 1'b1);
    nRate <= nRate + (rateRefused === 1'b1);
    nFire <= nFire + (sentenceFire === 1'b1);
    nFwd <= nFwd + (fwdDate === 1'b1);
    nPps <= nPps + (ppsOut === 1'b1);
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    miscompares++;
    end_sim();
  end

  // ============================================================
  // main sequence
  initial begin
    {cvKeyed, noCvs, notCurrent, navPending, cvExpiring, kdpDead, spoofError, fillValid, rateWr} = '0;
    {zeroizeCmd, zeroizeStart, zeroizeDone, zeroizeOk, timeFwdEn, loadTime, loadDate, almanacValid} = '0;
    {gpsLocked, gpsHoldover, forcedHoldCmd, forcedHoldExit, ppsBeforeLockEn, srcMode, rateVal} = '0;
    {setHour, setMin, setSec, setYear, setMonth, setDay, leapNv, leapGps} = '0;
    {xferState, pvtState, pvtMode, ytrack, instAlign} = {2'h2, 2'h1, 1'b1, 4'h5, 1'b0};
    step(4);
    chk("rstCodes", {3'h7, 2'h2}, {verifField, zeroField});
    chk("rstDate", {12'h7d0, 4'h1, 5'h01}, {year, month, day});
    rst = 1'b0;
    {cvKeyed, cvExpiring, kdpDead, spoofError} = 4'hf;
    step(2);
    chk("fieldsSet", 4'hf, {keyedField, expField, kdpField, spoofField});
    {cvKeyed, cvExpiring, kdpDead, spoofError} = 4'h0;
    step(2);
    chk("fieldsClr", 4'h0, {keyedField, expField, kdpField, spoofField});
    for (int i = 0; i < 4; i++) begin
      {noCvs, notCurrent, navPending} = vIn[i];
      step(2);
      chk("verif", vExp[i], verifField);
    end
    pulse(fillValid);
    step(P - 5);
    chk("fillHeld", 1, keyFillField);
    pulse(zeroizeCmd);
    step(3);
    chk("zeroNoStart", {16'h1, 16'h0}, {nRef[15:0], nReq[15:0]});
    zeroizeStart = 1'b1;
    pulse(zeroizeCmd);
    step(3);
    chk("zeroReq", 1, nReq);
    pulse(zeroizeDone);
    step(3);
    chk("zeroFail", ZERO_FAIL, zeroField);
    zeroizeOk = 1'b1;
    pulse(zeroizeCmd);
    pulse(zeroizeDone);
    step(2);
    chk("zeroOk", ZERO_OK, zeroField);
    rateVal = 8'h01;
    pulse(rateWr);
    step(2 * P);
    chk("warmRefused", {16'h1, 16'h0}, {nRate[15:0], nFire[15:0]});
    chk("ppsHidden", 0, nPps);
    gpsLocked = 1'b1;
    step(2);
    chk("locked", 1, lockState);
    pulse(forcedHoldCmd);
    step(2);
    chk("forcedHold", 2'h1, {lockState, holdState});
    step(3 * P);
    pulse(forcedHoldExit);
    step(2);
    chk("holdExit", 2'h2, {lockState, holdState});
    step(2 * P);
    chk("holdSecs", 32'h3, holdSecs);
    chk("ppsAfterLock", 1, nPps > 0);
    srcMode = 2'h1;
    step(2);
    chk("extSel", 1, refSelExt);
    srcMode = 2'h2;
    gpsHoldover = 1'b1;
    step(2);
    chk("autoExt", 1, refSelExt);
    gpsHoldover = 1'b0;
    step(2);
    chk("autoBack", 0, refSelExt);
    leapNv = 8'h12;
    leapGps = 8'h13;
    step(2);
    chk("leapNv", 8'h12, leapOut);
    almanacValid = 1'b1;
    step(2);
    chk("leapGps", 8'h13, leapOut);
    chk("tintAligned", 32'h0, tint[31:0]);
    step(115 * P);
    rateVal = 8'h02;
    timeFwdEn = 1'b1;
    pulse(rateWr);
    step(2 * P);
    f0 = nFire;
    w0 = nFwd;
    step(6 * P);
    chk("rateTaken", 1, nRate);
    chk("sentences", 3, nFire - f0);
    chk("fwdDates", 6, nFwd - w0);
    for (int i = 0; i < 2 * P && fwdDate !== 1'b1; i++) step(1);
    {setHour, setMin, setSec, setYear, setMonth, setDay} = {5'h17, 6'h3b, 6'h3b, 12'h7d1, 4'hc, 5'h1f};
    {loadTime, loadDate} = 2'h3;
    step(1);
    {loadTime, loadDate} = 2'h0;
    step(P);
    chk("timeWrap", 0, {hour, minute, second});
    chk("dateWrap", {12'h7d2, 4'h1, 5'h01}, {year, month, day});
    chk("stTime", {5'h17, 6'h3b, 6'h3b}, {stHour, stMin, stSec});
    chk("stSum", 8'h34, stChecksum);
    // external pulse sits 20 cycles after the satellite pulse, so 800 ns after the jump
    srcMode = 2'h1;
    pulse(instAlign);
    step(2 * P);
    chk("tintExt", 32'h1f40, tint[31:0]);
    end_sim();
  end
endmodule
